// file: sar_pkg.sv
// Shared constants and types for the interleaved converter sequencer
// Summary of operation
// [RULE1] Sixteen identical converter sections, one shared reference.
// [RULE2] Sixteen-phase generator from input clock drives everything.
// [RULE3] Results leave through 11-bit 16:1 mux plus correction.
// [RULE4] One conversion takes exactly sixteen clock cycles.
// [RULE5] Cycles: zero, autozero, autocal, sample, convert, transfer.
// [RULE6] Neighbouring sections offset by exactly one cycle.
// [RULE7] Exactly one section samples each clock cycle.
// [RULE8] Sixteen-phase cycle repeats with no gap.
// [RULE9] Output word appears twelve cycles after its sample.
// [RULE10] Auto-zero accumulates several comparator responses before adjusting.
// [RULE11] Auto-calibrate trims both MSB and LSB reference gain.
// [RULE12] Gain error integrated into per-section calibration value.
// [RULE13] Non-sampling sections isolated from the input.
// [RULE14] Calibration runs in background without interrupting data.
// [RULE15] Calibration starts by itself after power-up.
// [RULE16] Each trim step smaller than one 10-bit LSB.
// [RULE17] Output uncalibrated before ten thousand cycles.
// [RULE18] Clock must run continuously to keep calibration.
// [RULE19] Clock high 40-60 percent, period at least 40 ns.
// [RULE20] Hold logic inputs low until supplies settle; the host holds output_enable low only during reset.
// [RULE21] Code, overrange registered on rising edge, straight binary.
// [RULE22] Data outputs released while output enable is high.
// [RULE23] Overrange forces all ten code bits to one.
// [RULE24] Valid strobe pulses once per clock with word.
`default_nettype none
package sar_pkg;
    localparam int unsigned NUM_SECTIONS = 16;
    localparam int unsigned PHASE_W = 4;
    localparam int unsigned WORD_W = 11;
    localparam int unsigned CODE_W = 10;
    localparam int unsigned TRIM_W = 16;
    // Trim carries 6 fraction bits below one 10-bit LSB
    localparam int unsigned TRIM_FRAC = 6;
    localparam logic [3:0] PH_REF_ZERO = 4'h0;
    localparam logic [3:0] PH_AUTO_ZERO = 4'h1;
    localparam logic [3:0] PH_AUTO_CAL = 4'h2;
    localparam logic [3:0] PH_SAMPLE = 4'h3;
    localparam logic [3:0] PH_CONV_FIRST = 4'h4;
    localparam logic [3:0] PH_CONV_LAST = 4'he;
    localparam logic [3:0] PH_TRANSFER = 4'hf;
    localparam int unsigned LATENCY_CYC = 12;
    localparam int unsigned ACCUM_SAMPLES = 8;
    localparam int unsigned CAL_MIN_CYC = 10000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CLOCK_PERIOD_TIME_MIN_NS = 40;
    localparam int unsigned CLOCK_HIGH_FRACTION_MIN = 40;
    localparam int unsigned CLOCK_HIGH_FRACTION_MAX = 60;
    localparam int unsigned FIFO_DEPTH = 8;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_INITIAL = 2'b01,
        CAL_TRACKING = 2'b10
    } cal_state_e;
endpackage : sar_pkg
`default_nettype wire

// file: sar_link_if.sv
// Interface between converter device and capture logic
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
    logic [9:0] conversion_code_outputs;
    logic conversion_code_oe_n;
    logic overrange_flag;
    logic data_valid_strobe;
    logic output_enable;
    modport device (
        output conversion_code_outputs,
        output conversion_code_oe_n,
        output overrange_flag,
        output data_valid_strobe,
        input output_enable
    );
    modport host (
        input conversion_code_outputs,
        input conversion_code_oe_n,
        input overrange_flag,
        input data_valid_strobe,
        output output_enable
    );
endinterface : sar_link_if
`default_nettype wire

// file: sar_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_s;
    fifo_s st_ff, nxt_st;
    logic full, empty;
    assign empty = st_ff.wr == st_ff.rd;
    assign full = (st_ff.wr[AW] != st_ff.rd[AW]) && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st_ff.mem[st_ff.rd[AW-1:0]];
    always_comb begin
        nxt_st = st_ff;
        if (in_valid && !full) begin
            nxt_st.mem[st_ff.wr[AW-1:0]] = in_data;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : sar_fifo
`default_nettype wire

// file: sar_device.sv
// Device end: sixteen-phase sequencer, section model, calibration, output stage
`timescale 1ns/1ps
`default_nettype none
module sar_device #(
    parameter int unsigned CAL_MIN_CYCLES = sar_pkg::CAL_MIN_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [9:0] analog_sample,
    input wire logic analog_overrange,
    output logic [15:0] section_sampling,
    output logic cal_done,
    sar_link_if.device link
);
    localparam int unsigned N = sar_pkg::NUM_SECTIONS;
    localparam int unsigned TW = sar_pkg::TRIM_W;
    localparam int unsigned LAT = sar_pkg::LATENCY_CYC;
    // Accumulator decode points for the comparator responses of one trim update
    localparam logic [2:0] ACC_LAST = 3'(sar_pkg::ACCUM_SAMPLES - 1);
    localparam logic [3:0] ACC_HALF = 4'(sar_pkg::ACCUM_SAMPLES / 2);
    localparam logic [3:0] ACC_FULL = 4'(sar_pkg::ACCUM_SAMPLES);

    // The calibration counter is 20 bits wide
    if (CAL_MIN_CYCLES < 1 || CAL_MIN_CYCLES > 32'h000fffff) begin : g_bad_cal
        $error("CAL_MIN_CYCLES out of range");
    end
    // One section per generator phase, or some phase would sample nothing
    if (N != (1 << sar_pkg::PHASE_W)) begin : g_bad_sections
        $error("section count must match the phase range");
    end
    // The word leaves in the transfer cycle, so the schedule itself sets the latency
    if (int'(sar_pkg::PH_TRANSFER) - int'(sar_pkg::PH_SAMPLE) != int'(LAT)) begin : g_bad_latency
        $error("sample to transfer distance must equal the latency");
    end
    if (int'(sar_pkg::PH_CONV_LAST) - int'(sar_pkg::PH_CONV_FIRST) + 1 != sar_pkg::WORD_W) begin : g_bad_steps
        $error("one bit trial per word bit is needed");
    end
    // Counters wrap at eight, so only eight responses per update are served
    if (sar_pkg::ACCUM_SAMPLES != 8) begin : g_bad_accum
        $error("accumulation count out of range");
    end

    // Per-section state of one successive-approximation section
    typedef struct packed {
        logic [9:0] held;
        logic held_ovr;
        logic [10:0] sar_reg;
        logic [3:0] zero_acc;
        logic [2:0] zero_cnt;
        logic [3:0] gain_acc;
        logic [2:0] gain_cnt;
        logic signed [TW-1:0] offset_trim;
        logic signed [TW-1:0] msb_gain;
        logic signed [TW-1:0] lsb_gain;
    } section_s;

    typedef struct packed {
        logic [3:0] phase;
        section_s [N-1:0] sec;
        logic [19:0] cal_cnt;
        sar_pkg::cal_state_e cal_state;
        logic [9:0] code;
        logic ovr;
        logic strobe_on;
        logic [1:0] oe_sync;
    } dev_s;
    dev_s st_ff, nxt_st;

    // Phase of section k given generator phase
    function automatic logic [3:0] sec_phase(input logic [3:0] gen, input int unsigned k);
        sec_phase = gen - k[3:0];
    endfunction : sec_phase

    // Sub-LSB trim step; sign chosen by comparator majority
    function automatic logic signed [TW-1:0] trim_step(input logic signed [TW-1:0] v, input logic [3:0] acc);
        if (acc > ACC_HALF) begin
            trim_step = v - $signed(TW'(1)); // [RULE16]
        end else if (acc < ACC_HALF) begin
            trim_step = v + $signed(TW'(1)); // [RULE16]
        end else begin
            trim_step = v;
        end
    endfunction : trim_step

    // Comparator response to the reference zero, modelled from the trim sign
    function automatic logic zero_resp(input logic signed [TW-1:0] trim, input logic ph_bit);
        zero_resp = trim[TW-1] ^ ph_bit;
    endfunction : zero_resp

    // Comparator response to the calibration reference, modelled from both gain trims
    function automatic logic gain_resp(input logic signed [TW-1:0] msb, input logic signed [TW-1:0] lsb);
        gain_resp = msb[TW-1] ^ lsb[0];
    endfunction : gain_resp

    // Adds the whole-LSB part of the offset trim and clamps to the code range.
    // Overrange words pass untouched, so the trim can neither make nor hide an overrange.
    function automatic logic [10:0] correct_word(input logic [10:0] raw, input logic signed [TW-1:0] trim);
        logic signed [TW-1:0] sum;
        sum = $signed(TW'(raw)) + (trim >>> sar_pkg::TRIM_FRAC);
        if (raw[10]) begin
            correct_word = raw;
        end else if (sum[TW-1]) begin
            correct_word = '0;
        end else if (|sum[TW-2:10]) begin
            correct_word = 11'h3ff;
        end else begin
            correct_word = sum[10:0];
        end
    endfunction : correct_word

    logic [10:0] corrected;
    logic [3:0] out_idx;

    always_comb begin
        logic [3:0] p;
        logic cmp;
        logic [10:0] trial;
        p = '0;
        cmp = 1'b0;
        trial = '0;
        nxt_st = st_ff;
        nxt_st.phase = st_ff.phase + 4'h1; // [RULE2] [RULE8]
        nxt_st.oe_sync = {st_ff.oe_sync[0], link.output_enable};
        for (int k = 0; k < N; k++) begin // [RULE1]
            p = sec_phase(st_ff.phase, k); // [RULE6]
            // Calibration comparator decisions modelled from trim bits; bit trials compare the held sample with the trial
            case (p) // [RULE4] [RULE5]
                sar_pkg::PH_REF_ZERO: begin
                    nxt_st.sec[k].sar_reg = '0;
                end
                sar_pkg::PH_AUTO_ZERO: begin // [RULE10] [RULE14]
                    cmp = zero_resp(st_ff.sec[k].offset_trim, st_ff.phase[0]);
                    nxt_st.sec[k].zero_acc = st_ff.sec[k].zero_acc + {3'h0, cmp};
                    nxt_st.sec[k].zero_cnt = st_ff.sec[k].zero_cnt + 3'h1;
                    if (st_ff.sec[k].zero_cnt == ACC_LAST) begin
                        nxt_st.sec[k].offset_trim = trim_step(st_ff.sec[k].offset_trim, st_ff.sec[k].zero_acc);
                        nxt_st.sec[k].zero_acc = '0;
                    end
                end
                sar_pkg::PH_AUTO_CAL: begin // [RULE11] [RULE12]
                    cmp = gain_resp(st_ff.sec[k].msb_gain, st_ff.sec[k].lsb_gain);
                    nxt_st.sec[k].gain_acc = st_ff.sec[k].gain_acc + {3'h0, cmp};
                    nxt_st.sec[k].gain_cnt = st_ff.sec[k].gain_cnt + 3'h1;
                    if (st_ff.sec[k].gain_cnt == ACC_LAST) begin
                        nxt_st.sec[k].msb_gain = trim_step(st_ff.sec[k].msb_gain, st_ff.sec[k].gain_acc);
                        nxt_st.sec[k].lsb_gain = trim_step(st_ff.sec[k].lsb_gain, ACC_FULL - st_ff.sec[k].gain_acc);
                        nxt_st.sec[k].gain_acc = '0;
                    end
                end
                sar_pkg::PH_SAMPLE: begin // [RULE7] [RULE13]
                    nxt_st.sec[k].held = analog_sample;
                    nxt_st.sec[k].held_ovr = analog_overrange;
                end
                sar_pkg::PH_TRANSFER: begin
                end
                default: begin
                    // Bit trial: MSB first over 11 steps
                    trial = st_ff.sec[k].sar_reg | (11'h400 >> (p - sar_pkg::PH_CONV_FIRST));
                    nxt_st.sec[k].sar_reg[sar_pkg::PH_CONV_LAST - p] = 1'b1;
                    if ({st_ff.sec[k].held_ovr, st_ff.sec[k].held} < trial) begin
                        nxt_st.sec[k].sar_reg[sar_pkg::PH_CONV_LAST - p] = 1'b0;
                    end
                end
            endcase
        end

        // The 16:1 mux picks the section that is in its transfer cycle
        out_idx = st_ff.phase - sar_pkg::PH_TRANSFER; // [RULE3]
        corrected = correct_word(st_ff.sec[out_idx].sar_reg, st_ff.sec[out_idx].offset_trim); // [RULE3]
        // Registered straight from the transfer cycle; any extra stage would break the latency
        nxt_st.ovr = corrected[10]; // [RULE9] [RULE21]
        nxt_st.code = corrected[10] ? 10'h3ff : corrected[9:0]; // [RULE23]
        nxt_st.strobe_on = 1'b1; // [RULE24]

        case (st_ff.cal_state) // [RULE15] [RULE17]
            sar_pkg::CAL_IDLE: begin
                nxt_st.cal_state = sar_pkg::CAL_INITIAL;
            end
            sar_pkg::CAL_INITIAL: begin
                nxt_st.cal_cnt = st_ff.cal_cnt + 20'h00001;
                if (st_ff.cal_cnt >= CAL_MIN_CYCLES[19:0] - 20'h00001) begin
                    nxt_st.cal_state = sar_pkg::CAL_TRACKING;
                end
            end
            sar_pkg::CAL_TRACKING: begin
                nxt_st.cal_state = sar_pkg::CAL_TRACKING;
            end
            default: begin
                nxt_st.cal_state = sar_pkg::CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        section_sampling = '0;
        section_sampling[st_ff.phase - sar_pkg::PH_SAMPLE] = 1'b1; // [RULE7] [RULE13]
    end

    assign cal_done = st_ff.cal_state == sar_pkg::CAL_TRACKING;
    assign link.conversion_code_outputs = st_ff.code;
    assign link.overrange_flag = st_ff.ovr;
    // Enable is a pin: synchronised; high releases the data pins
    assign link.conversion_code_oe_n = st_ff.oe_sync[1]; // [RULE22]
    // Strobe is a level that pulses each clock: high in the first half period
    assign link.data_valid_strobe = st_ff.strobe_on & sys_clk; // [RULE24]
endmodule : sar_device
`default_nettype wire

// file: sar_host.sv
// Capture end: samples converter words into a FIFO once calibration time passes
`timescale 1ns/1ps
`default_nettype none
module sar_host #(
    parameter int unsigned CAL_MIN_CYCLES = sar_pkg::CAL_MIN_CYC,
    parameter int unsigned DEPTH = sar_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic outputs_off,
    output logic word_valid,
    input wire logic word_ready,
    output logic [10:0] word_data,
    output logic word_calibrated,
    output logic overflow,
    sar_link_if.host link
);
    if (CAL_MIN_CYCLES < 1 || CAL_MIN_CYCLES > 32'h000fffff) begin : g_bad_cal
        $error("CAL_MIN_CYCLES out of range");
    end
    typedef struct packed {
        logic [1:0][10:0] sync;
        logic [19:0] cnt;
        logic calibrated;
        logic oe;
        logic ovf;
    } host_s;
    host_s st_ff, nxt_st;
    logic fifo_ready;
    always_comb begin
        nxt_st = st_ff;
        // Pins pass two flops before use
        nxt_st.sync = {st_ff.sync[0], {link.overrange_flag, link.conversion_code_outputs}};
        // Enable input held low only while reset is asserted; afterwards it follows outputs_off
        nxt_st.oe = outputs_off; // [RULE20] [RULE22]
        if (!st_ff.calibrated) begin // [RULE17] [RULE18]
            nxt_st.cnt = st_ff.cnt + 20'h00001;
            if (st_ff.cnt >= CAL_MIN_CYCLES[19:0] + 20'h00002) begin
                nxt_st.calibrated = 1'b1;
            end
        end
        if (st_ff.calibrated && !st_ff.oe && !fifo_ready) begin
            nxt_st.ovf = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign link.output_enable = st_ff.oe;
    assign word_calibrated = st_ff.calibrated;
    assign overflow = st_ff.ovf;
    // One word per clock while enabled; a stalled drain drops words and flags it
    sar_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(st_ff.calibrated && !st_ff.oe),
        .in_ready(fifo_ready),
        .in_data(st_ff.sync[1]),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule : sar_host
`default_nettype wire

// file: sar_link_sva.sv
// Checker on the link between converter device and capture logic
`timescale 1ns/1ps
`default_nettype none
module sar_link_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [9:0] conversion_code_outputs,
    input wire logic conversion_code_oe_n,
    input wire logic overrange_flag,
    input wire logic data_valid_strobe,
    input wire logic output_enable
);
    // Saturating count of edges since reset; the strobe gate may need a cycle to open
    logic [1:0] cyc_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cyc_ff <= 2'h0;
        end else if (cyc_ff != 2'h3) begin
            cyc_ff <= cyc_ff + 2'h1;
        end
    end
    AST_OVR_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
        overrange_flag |-> conversion_code_outputs == 10'h3ff) else $error("code not all ones under overrange");
    AST_OE_RELEASE: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(output_enable) |-> ##[1:3] conversion_code_oe_n) else $error("data pins not released");
    AST_OE_RESUME: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(output_enable) |-> ##[1:3] !conversion_code_oe_n) else $error("data pins not driven again");
    AST_OE_ROSE_CAUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(conversion_code_oe_n) |-> output_enable) else $error("pins released without request");
    AST_OE_FELL_CAUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(conversion_code_oe_n) |-> !output_enable) else $error("pins driven while release requested");
    AST_STROBE_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        !data_valid_strobe) else $error("strobe high in clock low half");
    AST_STROBE_HIGH: assert property (@(negedge sys_clk) disable iff (!rstn)
        cyc_ff == 2'h3 |-> data_valid_strobe) else $error("strobe missing in clock high half");
    AST_RESET_VALUES: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(rstn) |-> conversion_code_outputs == 10'h0 && !overrange_flag && !conversion_code_oe_n)
        else $error("outputs not cleared by reset");
    COV_OVR: cover property (@(posedge sys_clk) disable iff (!rstn) overrange_flag);
    COV_RELEASE: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(conversion_code_oe_n));
    COV_RESUME: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(conversion_code_oe_n));
endmodule : sar_link_sva
`default_nettype wire

// file: tb.sv
// Testbench joining converter device and capture logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk;
    logic rstn;
    logic [9:0] analog_sample;
    logic analog_overrange;
    logic [15:0] section_sampling;
    logic cal_done;
    logic outputs_off;
    logic word_valid;
    logic word_ready;
    logic [10:0] word_data;
    logic word_calibrated;
    logic overflow;
    int error_cnt;
    int comparisons;
    logic [9:0] hist [0:63];
    logic hovr [0:63];
    logic [15:0] prev_sel;
    sar_link_if sar_link_if_i ();
    // Short calibration window keeps the run brief
    sar_device #(.CAL_MIN_CYCLES(20)) sar_device_i (.sys_clk(sys_clk), .rstn(rstn),
        .analog_sample(analog_sample), .analog_overrange(analog_overrange),
        .section_sampling(section_sampling), .cal_done(cal_done), .link(sar_link_if_i.device));
    sar_host #(.CAL_MIN_CYCLES(20), .DEPTH(8)) sar_host_i (.sys_clk(sys_clk), .rstn(rstn),
        .outputs_off(outputs_off), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .word_calibrated(word_calibrated), .overflow(overflow), .link(sar_link_if_i.host));
    sar_link_sva sar_link_sva_i (.sys_clk(sys_clk), .rstn(rstn),
        .conversion_code_outputs(sar_link_if_i.conversion_code_outputs),
        .conversion_code_oe_n(sar_link_if_i.conversion_code_oe_n), .overrange_flag(sar_link_if_i.overrange_flag),
        .data_valid_strobe(sar_link_if_i.data_valid_strobe), .output_enable(sar_link_if_i.output_enable));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    // Background trim may move the code by one step, so one LSB of slack is allowed
    function automatic logic near(input logic [9:0] a, input logic [9:0] b);
        return ((a - b) === 10'h0) || ((a - b) === 10'h1) || ((b - a) === 10'h1);
    endfunction : near
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rstn = 1'b0;
        analog_sample = 10'h0;
        analog_overrange = 1'b0;
        outputs_off = 1'b0;
        word_ready = 1'b1;
        step(10);
        rstn = 1'b1;
        step(12);
        chk(cal_done === 1'b0, "calibration flagged too early");
        chk(word_valid === 1'b0, "word captured before calibration");
        step(15);
        chk(cal_done === 1'b1, "calibration never finished");
        step(10);
        chk(word_calibrated === 1'b1, "capture side not calibrated");
        $display("test calibration done");
        prev_sel = section_sampling;
        for (int k = 0; k < 60; k++) begin
            step(1);
            hist[k] = analog_sample;
            hovr[k] = analog_overrange;
            chk($onehot(section_sampling) === 1'b1, "not one section sampling");
            chk(section_sampling === {prev_sel[14:0], prev_sel[15]}, "section order broken");
            prev_sel = section_sampling;
            if (k >= 12 && hovr[k-12]) begin
                chk(sar_link_if_i.overrange_flag === 1'b1, "overrange flag missing");
                chk(sar_link_if_i.conversion_code_outputs === 10'h3ff, "code not forced high");
            end else if (k >= 12) begin
                chk(sar_link_if_i.overrange_flag === 1'b0, "false overrange");
                chk(near(sar_link_if_i.conversion_code_outputs, hist[k-12]), "word latency wrong");
            end
            analog_sample = 10'(k * 5 + 3);
            analog_overrange = (k >= 20 && k < 25);
        end
        analog_overrange = 1'b0;
        $display("test stream done");
        outputs_off = 1'b1;
        step(4);
        chk(sar_link_if_i.conversion_code_oe_n === 1'b1, "pins not released");
        outputs_off = 1'b0;
        step(4);
        chk(sar_link_if_i.conversion_code_oe_n === 1'b0, "pins not driven");
        $display("test output enable done");
        chk(overflow === 1'b0, "overflow without stall");
        analog_sample = 10'h0aa;
        step(20);
        word_ready = 1'b0;
        step(20);
        chk(word_valid === 1'b1, "full buffer shows no word");
        chk(overflow === 1'b1, "dropped word not flagged");
        word_ready = 1'b1;
        for (int k = 0; k < 8; k++) begin
            chk(word_data[10] === 1'b0 && near(word_data[9:0], 10'h0aa), "buffered word wrong");
            step(1);
        end
        chk(overflow === 1'b1, "overflow not sticky");
        $display("test buffer done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
